// ### cpwm_consts.svh
// Register map, field positions and reset values of the compare array
// Behaviour
// [RULE_01] Toggle mode inverts the pin when enabled compare hits the count.
// [RULE_02] 8-bit PWM period is one wrap of the counter low byte, 256 counts.
// [RULE_03] 8-bit PWM goes high when low byte reaches the low compare.
// [RULE_04] At low byte wrap in 8-bit PWM, high compare loads low compare.
// [RULE_05] 8-bit PWM output returns low at the low byte wrap.
// [RULE_06] Firmware puts all three modules of an array in 10-bit PWM.
// [RULE_07] 10-bit PWM uses a 10-bit counter and a 10-bit compare value.
// [RULE_08] 10-bit PWM goes high at counter >= compare, low at counter wrap.
// [RULE_09] Upper six bits of counter high half and high compare are ignored.
// [RULE_10] Firmware writes the low compare byte before the high byte.
// [RULE_11] Low compare write clears compare enable; high write sets it.
// [RULE_12] 16-bit PWM: value 0000h gives full duty, FFFFh the smallest duty.
// [RULE_13] With compare enable clear the PWM output never goes high.
// [RULE_14] Bit 7 written as one starts both counters; a zero does nothing.
// [RULE_15] Run bit starts the counter; only a firmware clear stops it.
// [RULE_16] Overflow interrupt is raised while flag and bit 5 are set.
// [RULE_17] Stop-in-idle bit 4 halts the counter during CPU idle when set.
// [RULE_18] Each array has its control register, each module a mode register.
// [RULE_19] Two-bit clock select field picks the counter clock prescale.
`ifndef CPWM_CONSTS_SVH
`define CPWM_CONSTS_SVH

`define CPWM_CTRL0      8'ha4
`define CPWM_CTRL1      8'hbc
`define CPWM_STATUS     8'ha5
`define CPWM_CNTL0      8'ha6
`define CPWM_CNTH0      8'ha7
`define CPWM_CNTL1      8'hbd
`define CPWM_CNTH1      8'hbe
`define CPWM_MODE_BASE  8'hc0
`define CPWM_CMPL_BASE  8'hc8
`define CPWM_CMPH_BASE  8'hd0

`define CPWM_CTRL_RESET 8'h00
`define CPWM_CTRL_WMASK 8'hf3
`define CPWM_BIT_ALL    7
`define CPWM_BIT_RUN    6
`define CPWM_BIT_IE     5
`define CPWM_BIT_IDLE   4
`define CPWM_MODE_EN    7
`define CPWM_N_ARRAY    2
`define CPWM_N_MOD      6
`define CPWM_MOD_PER    3

`endif

// ### cpwm_pkg.sv
// Types shared by the compare array design
`default_nettype none
package cpwm_pkg;
	typedef enum logic [2:0] {
		MODE_OFF,
		MODE_TOGGLE,
		MODE_PWM8,
		MODE_PWM16,
		MODE_PWM10
	} cmp_mode_t;
	typedef logic [7:0] byte_t;
endpackage
`default_nettype wire

// ### cpwm_counter.sv
// Free-running counter of one array with prescaler and wrap pulses
`timescale 1ns/10ps
`default_nettype none
module cpwm_counter (
	input  wire logic        clock_i,
	input  wire logic        rstn_i,
	input  wire logic        run_i,
	input  wire logic [1:0]  clk_sel_i,
	input  wire logic        wide10_i,
	output logic             tick_o,
	output logic [15:0]      count_o,
	output logic             ovf8_o,
	output logic             ovf_o
);
	import cpwm_pkg::*;

	logic [2:0]  pre;
	logic [2:0]  next_pre;
	logic [15:0] next_count;

	// Prescale 1, 2, 4 or 8 core clocks per count
	always_comb begin
		case (clk_sel_i) // RULE_19
			2'h0:    tick_o = run_i;
			2'h1:    tick_o = run_i & pre[0];
			2'h2:    tick_o = run_i & (&pre[1:0]);
			default: tick_o = run_i & (&pre);
		endcase
		ovf8_o = tick_o & (&count_o[7:0]); // RULE_02
		// In 10-bit mode the wrap comes after 1024 counts
		ovf_o = tick_o & (wide10_i ? (&count_o[9:0]) : (&count_o)); // RULE_07
		next_pre = run_i ? pre + 3'h1 : pre;
		next_count = count_o;
		if (ovf_o) begin
			next_count = 16'h0000;
		end else if (tick_o) begin
			next_count = count_o + 16'h0001;
		end
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pre <= 3'h0;
			count_o <= 16'h0000;
		end else begin
			pre <= next_pre;
			count_o <= next_count;
		end
	end

	property p_wrap10;
		@(posedge clock_i) disable iff (!rstn_i)
		wide10_i && tick_o && count_o[9:0] == 10'h3ff |=> count_o == 16'h0000;
	endproperty
	a_wrap10: assert property (p_wrap10) // RULE_07
		else $error("10-bit wrap missed");

	property p_step;
		@(posedge clock_i) disable iff (!rstn_i)
		tick_o && !ovf_o |=> count_o == $past(count_o) + 16'h0001;
	endproperty
	a_step: assert property (p_step) // RULE_02
		else $error("counter did not step");
endmodule
`default_nettype wire

// ### cpwm_compare.sv
// One compare module: toggle and PWM output generation
`timescale 1ns/10ps
`default_nettype none
module cpwm_compare (
	input  wire logic               clock_i,
	input  wire logic               rstn_i,
	input  wire cpwm_pkg::cmp_mode_t mode_i,
	input  wire logic               cmp_en_i,
	input  wire cpwm_pkg::byte_t    cmp_lo_i,
	input  wire cpwm_pkg::byte_t    cmp_hi_i,
	input  wire logic [15:0]        count_i,
	input  wire logic               tick_i,
	input  wire logic               ovf8_i,
	input  wire logic               ovf_i,
	output logic                    pin_o
);
	import cpwm_pkg::*;

	logic        next_pin;
	logic [15:0] val16;
	logic [9:0]  val10;

	always_comb begin
		val16 = {cmp_hi_i, cmp_lo_i};
		val10 = {cmp_hi_i[1:0], cmp_lo_i}; // RULE_09
		next_pin = pin_o;
		case (mode_i)
			MODE_TOGGLE: begin
				if (tick_i && cmp_en_i && count_i == val16) begin // RULE_01
					next_pin = !pin_o;
				end
			end
			MODE_PWM8: begin
				if (ovf8_i) begin
					next_pin = 1'b0; // RULE_05
				end else if (tick_i && cmp_en_i && count_i[7:0] >= cmp_lo_i) begin
					next_pin = 1'b1; // RULE_03
				end
			end
			// Level compare: 0000h is always high, FFFFh high one count
			MODE_PWM16: next_pin = cmp_en_i && count_i >= val16; // RULE_12 RULE_13
			MODE_PWM10: begin
				if (ovf_i) begin
					next_pin = 1'b0; // RULE_08
				end else if (tick_i && cmp_en_i && count_i[9:0] >= val10) begin
					next_pin = 1'b1; // RULE_08
				end
			end
			default: next_pin = 1'b0;
		endcase
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pin_o <= 1'b0;
		end else begin
			pin_o <= next_pin;
		end
	end

	property p_toggle;
		@(posedge clock_i) disable iff (!rstn_i)
		mode_i == MODE_TOGGLE && tick_i && cmp_en_i && count_i == val16
		|=> pin_o != $past(pin_o);
	endproperty
	a_toggle: assert property (p_toggle) // RULE_01
		else $error("no toggle on match");

	property p_off;
		@(posedge clock_i) disable iff (!rstn_i)
		(mode_i == MODE_PWM8 || mode_i == MODE_PWM16) && !cmp_en_i && !pin_o
		|=> !pin_o;
	endproperty
	a_off: assert property (p_off) // RULE_13
		else $error("pulse with compare disabled");

	property p_pwm8_low;
		@(posedge clock_i) disable iff (!rstn_i)
		mode_i == MODE_PWM8 && ovf8_i |=> !pin_o;
	endproperty
	a_pwm8_low: assert property (p_pwm8_low) // RULE_05
		else $error("pwm8 not low at wrap");

	property p_full;
		@(posedge clock_i) disable iff (!rstn_i)
		mode_i == MODE_PWM16 && cmp_en_i && val16 == 16'h0000 |=> pin_o;
	endproperty
	a_full: assert property (p_full) // RULE_12
		else $error("0000h not full duty");
endmodule
`default_nettype wire

// ### cpwm_top.sv
// Compare array top: special function registers, two counters, six modules
`timescale 1ns/10ps
`default_nettype none
`include "cpwm_consts.svh"
module cpwm_top (
	input  wire logic            clock_i,
	input  wire logic            rstn_i,
	input  wire logic [7:0]      sfr_addr_i,
	input  wire cpwm_pkg::byte_t sfr_wdata_i,
	input  wire logic            sfr_wr_i,
	input  wire logic            sfr_rd_i,
	output cpwm_pkg::byte_t      sfr_rdata_o,
	input  wire logic            cpu_idle_i,
	output logic [5:0]           pin_o,
	output logic [1:0]           ovf_irq_o
);
	import cpwm_pkg::*;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] base,
		input int n);
		return a == base + 8'(n);
	endfunction

	byte_t       ctrl      [2];
	byte_t       next_ctrl [2];
	logic [2:0]  mode      [6];
	logic [2:0]  next_mode [6];
	byte_t       lo        [6];
	byte_t       next_lo   [6];
	byte_t       hi        [6];
	byte_t       next_hi   [6];
	logic [5:0]  cen;
	logic [5:0]  next_cen;
	logic [1:0]  ovf_flag;
	logic [1:0]  next_ovf_flag;
	byte_t       next_rdata;

	logic [15:0] count [2];
	logic [1:0]  tick;
	logic [1:0]  ovf8;
	logic [1:0]  ovf;
	logic [1:0]  run;
	logic [1:0]  wide10;
	logic        wr_ctrl0;

	assign wr_ctrl0 = sfr_wr_i && sfr_addr_i == `CPWM_CTRL0;

	genvar ga;
	generate
		for (ga = 0; ga < `CPWM_N_ARRAY; ga++) begin : g_arr
			// Idle stop only pauses; the run bit itself is left alone
			assign run[ga] = ctrl[ga][`CPWM_BIT_RUN] &&
				!(cpu_idle_i && ctrl[ga][`CPWM_BIT_IDLE]); // RULE_17
			// The array's first module (0 or 3) speaks for it; firmware keeps all three alike
			assign wide10[ga] = mode[ga * `CPWM_MOD_PER] ==
				3'(MODE_PWM10); // RULE_06
			assign ovf_irq_o[ga] = ovf_flag[ga] &&
				ctrl[ga][`CPWM_BIT_IE]; // RULE_16
			cpwm_counter u_counter (
				.clock_i   (clock_i),
				.rstn_i    (rstn_i),
				.run_i     (run[ga]),
				.clk_sel_i (ctrl[ga][1:0]),
				.wide10_i  (wide10[ga]),
				.tick_o    (tick[ga]),
				.count_o   (count[ga]),
				.ovf8_o    (ovf8[ga]),
				.ovf_o     (ovf[ga])
			);
		end
	endgenerate

	genvar gm;
	generate
		for (gm = 0; gm < `CPWM_N_MOD; gm++) begin : g_mod
			cpwm_compare u_compare (
				.clock_i  (clock_i),
				.rstn_i   (rstn_i),
				.mode_i   (cmp_mode_t'(mode[gm])),
				.cmp_en_i (cen[gm]),
				.cmp_lo_i (lo[gm]),
				.cmp_hi_i (hi[gm]),
				.count_i  (count[gm / `CPWM_MOD_PER]),
				.tick_i   (tick[gm / `CPWM_MOD_PER]),
				.ovf8_i   (ovf8[gm / `CPWM_MOD_PER]),
				.ovf_i    (ovf[gm / `CPWM_MOD_PER]),
				.pin_o    (pin_o[gm])
			);
		end
	endgenerate

	// Control registers, one per array
	always_comb begin
		next_ctrl[0] = ctrl[0];
		next_ctrl[1] = ctrl[1];
		if (wr_ctrl0) begin
			next_ctrl[0] = sfr_wdata_i & `CPWM_CTRL_WMASK; // RULE_18
		end
		if (sfr_wr_i && sfr_addr_i == `CPWM_CTRL1) begin
			next_ctrl[1] = sfr_wdata_i & `CPWM_CTRL_WMASK; // RULE_18
		end
		// A one starts both arrays together; a zero leaves them be
		if (wr_ctrl0 && sfr_wdata_i[`CPWM_BIT_ALL]) begin
			next_ctrl[0][`CPWM_BIT_RUN] = 1'b1; // RULE_14
			next_ctrl[1][`CPWM_BIT_RUN] = 1'b1; // RULE_14
		end
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ctrl[0] <= `CPWM_CTRL_RESET;
			ctrl[1] <= `CPWM_CTRL_RESET;
		end else begin
			ctrl[0] <= next_ctrl[0]; // RULE_15
			ctrl[1] <= next_ctrl[1]; // RULE_15
		end
	end

	// Mode and compare registers of the six modules
	always_comb begin
		for (int n = 0; n < `CPWM_N_MOD; n++) begin
			next_mode[n] = mode[n];
			next_lo[n] = lo[n];
			next_hi[n] = hi[n];
			next_cen[n] = cen[n];
			// Hardware reload; a firmware write in the same cycle wins
			if (ovf8[n / `CPWM_MOD_PER] && mode[n] == 3'(MODE_PWM8)) begin
				next_lo[n] = hi[n]; // RULE_04
			end
			if (sfr_wr_i && hit(sfr_addr_i, `CPWM_MODE_BASE, n)) begin
				next_mode[n] = sfr_wdata_i[2:0]; // RULE_18
			end
			if (sfr_wr_i && hit(sfr_addr_i, `CPWM_CMPL_BASE, n)) begin
				next_lo[n] = sfr_wdata_i;
				next_cen[n] = 1'b0; // RULE_11
			end
			// Low byte first, so the high write arms the comparator
			if (sfr_wr_i && hit(sfr_addr_i, `CPWM_CMPH_BASE, n)) begin
				next_hi[n] = sfr_wdata_i;
				next_cen[n] = 1'b1; // RULE_11 RULE_10
			end
		end
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			for (int n = 0; n < `CPWM_N_MOD; n++) begin
				mode[n] <= 3'h0;
				lo[n] <= 8'h00;
				hi[n] <= 8'h00;
			end
			cen <= 6'h00;
		end else begin
			for (int n = 0; n < `CPWM_N_MOD; n++) begin
				mode[n] <= next_mode[n];
				lo[n] <= next_lo[n];
				hi[n] <= next_hi[n];
			end
			cen <= next_cen;
		end
	end

	// Shared status: a zero written clears a flag, a new wrap wins
	always_comb begin
		next_ovf_flag = ovf_flag;
		if (sfr_wr_i && sfr_addr_i == `CPWM_STATUS) begin
			next_ovf_flag = ovf_flag & sfr_wdata_i[1:0];
		end
		next_ovf_flag = next_ovf_flag | ovf; // RULE_16
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ovf_flag <= 2'h0;
		end else begin
			ovf_flag <= next_ovf_flag;
		end
	end

	// Read data is captured on the read strobe; unmapped reads give zero
	always_comb begin
		next_rdata = sfr_rdata_o;
		if (sfr_rd_i) begin
			next_rdata = 8'h00;
			case (sfr_addr_i)
				`CPWM_CTRL0:  next_rdata = ctrl[0];
				`CPWM_CTRL1:  next_rdata = ctrl[1];
				`CPWM_STATUS: next_rdata = {6'h00, ovf_flag};
				`CPWM_CNTL0:  next_rdata = count[0][7:0];
				`CPWM_CNTH0:  next_rdata = count[0][15:8];
				`CPWM_CNTL1:  next_rdata = count[1][7:0];
				`CPWM_CNTH1:  next_rdata = count[1][15:8];
				default: begin
					for (int n = 0; n < `CPWM_N_MOD; n++) begin
						if (hit(sfr_addr_i, `CPWM_MODE_BASE, n)) begin
							next_rdata = {cen[n], 4'h0, mode[n]};
						end
						if (hit(sfr_addr_i, `CPWM_CMPL_BASE, n)) begin
							next_rdata = lo[n];
						end
						if (hit(sfr_addr_i, `CPWM_CMPH_BASE, n)) begin
							next_rdata = hi[n];
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sfr_rdata_o <= 8'h00;
		end else begin
			sfr_rdata_o <= next_rdata;
		end
	end

	property p_lo_clr;
		@(posedge clock_i) disable iff (!rstn_i)
		sfr_wr_i && sfr_addr_i == `CPWM_CMPL_BASE |=> !cen[0];
	endproperty
	a_lo_clr: assert property (p_lo_clr) // RULE_11
		else $error("enable not cleared");

	property p_hi_set;
		@(posedge clock_i) disable iff (!rstn_i)
		sfr_wr_i && sfr_addr_i == `CPWM_CMPH_BASE |=> cen[0];
	endproperty
	a_hi_set: assert property (p_hi_set) // RULE_11
		else $error("enable not set");

	property p_start_all;
		@(posedge clock_i) disable iff (!rstn_i)
		wr_ctrl0 && sfr_wdata_i[`CPWM_BIT_ALL]
		|=> ctrl[0][`CPWM_BIT_RUN] && ctrl[1][`CPWM_BIT_RUN];
	endproperty
	a_start_all: assert property (p_start_all) // RULE_14
		else $error("start-all failed");

	property p_run_hold;
		@(posedge clock_i) disable iff (!rstn_i)
		ctrl[1][`CPWM_BIT_RUN] && !(sfr_wr_i && sfr_addr_i == `CPWM_CTRL1)
		|=> ctrl[1][`CPWM_BIT_RUN];
	endproperty
	a_run_hold: assert property (p_run_hold) // RULE_15
		else $error("counter self-stopped");

	property p_irq;
		@(posedge clock_i) disable iff (!rstn_i)
		ovf[1] && ctrl[1][`CPWM_BIT_IE] &&
		!(sfr_wr_i && sfr_addr_i == `CPWM_CTRL1) |=> ovf_irq_o[1];
	endproperty
	a_irq: assert property (p_irq) // RULE_16
		else $error("overflow irq missing");

	property p_idle;
		@(posedge clock_i) disable iff (!rstn_i)
		cpu_idle_i && ctrl[0][`CPWM_BIT_IDLE] |-> !tick[0];
	endproperty
	a_idle: assert property (p_idle) // RULE_17
		else $error("counted in idle");

	property p_copy;
		@(posedge clock_i) disable iff (!rstn_i)
		ovf8[0] && mode[0] == 3'(MODE_PWM8) &&
		!(sfr_wr_i && sfr_addr_i == `CPWM_CMPL_BASE)
		|=> lo[0] == $past(hi[0]);
	endproperty
	a_copy: assert property (p_copy) // RULE_04
		else $error("no high to low reload");

	property p_flag_set;
		@(posedge clock_i) disable iff (!rstn_i)
		ovf[1] |=> ovf_flag[1];
	endproperty
	a_flag_set: assert property (p_flag_set) // RULE_16
		else $error("overflow flag lost");

	// A zero written clears the flag only when no wrap arrives with it
	property p_flag_clr;
		@(posedge clock_i) disable iff (!rstn_i)
		sfr_wr_i && sfr_addr_i == `CPWM_STATUS && !sfr_wdata_i[1] && !ovf[1]
		|=> !ovf_flag[1];
	endproperty
	a_flag_clr: assert property (p_flag_clr) // RULE_16
		else $error("overflow flag not cleared");

	property p_rd_hold;
		@(posedge clock_i) disable iff (!rstn_i)
		!sfr_rd_i |=> $stable(sfr_rdata_o);
	endproperty
	a_rd_hold: assert property (p_rd_hold) // RULE_18
		else $error("read data changed without a read");

	property p_mode_wr;
		@(posedge clock_i) disable iff (!rstn_i)
		sfr_wr_i && sfr_addr_i == `CPWM_MODE_BASE
		|=> mode[0] == $past(sfr_wdata_i[2:0]);
	endproperty
	a_mode_wr: assert property (p_mode_wr) // RULE_18
		else $error("mode register not written");

	// Idle without the stop bit must not slow the counter
	property p_idle_run;
		@(posedge clock_i) disable iff (!rstn_i)
		ctrl[1][`CPWM_BIT_RUN] && !ctrl[1][`CPWM_BIT_IDLE] &&
		ctrl[1][1:0] == 2'h0 |-> tick[1];
	endproperty
	a_idle_run: assert property (p_idle_run) // RULE_17 RULE_15
		else $error("counter stalled while allowed to run");
endmodule
`default_nettype wire

// ### counter_array_pwm_compare_bench.sv
// Self-checking bench for the compare array top
`timescale 1ns/10ps
`default_nettype none
module counter_array_pwm_compare_bench;
	import cpwm_pkg::*;
	logic       clock_i;
	logic       rstn_i;
	logic       sfr_wr;
	logic       sfr_rd;
	logic       idle;
	logic [7:0] addr;
	byte_t      wdata;
	byte_t      rdata;
	logic [5:0] pin;
	logic [1:0] irq;
	int         err_total;
	int         check_count;

	cpwm_top uut (
		.clock_i(clock_i),
		.rstn_i(rstn_i),
		.sfr_addr_i(addr),
		.sfr_wdata_i(wdata),
		.sfr_wr_i(sfr_wr),
		.sfr_rd_i(sfr_rd),
		.sfr_rdata_o(rdata),
		.cpu_idle_i(idle),
		.pin_o(pin),
		.ovf_irq_o(irq)
	);

	initial begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic complete_run();
		$display("checks=%0d errors=%0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic reg_wr(input logic [7:0] a, input byte_t d);
		@(posedge clock_i) #1;
		addr = a;
		wdata = d;
		sfr_wr = 1'b1;
		@(posedge clock_i) #1;
		sfr_wr = 1'b0;
	endtask

	task automatic reg_rd(input logic [7:0] a, output byte_t d);
		@(posedge clock_i) #1;
		addr = a;
		sfr_rd = 1'b1;
		@(posedge clock_i) #1;
		sfr_rd = 1'b0;
		d = rdata;
	endtask

	// Bounded wait; running out counts as a mismatch and ends the run
	task automatic wait_sig(input logic [7:0] i, input logic v, input int n);
		logic [7:0] s;
		s = {irq, pin};
		for (int k = 0; k < n && s[i] !== v; k++) begin
			@(posedge clock_i) #1;
			s = {irq, pin};
		end
		if (s[i] !== v) begin
			check(16'(s[i]), 16'(v));
			complete_run();
		end
	endtask

	task automatic highs(input int i, input int n, output int h);
		h = 0;
		repeat (n) begin
			@(posedge clock_i) #1;
			h += (pin[i] === 1'b1);
		end
	endtask

	// Counter low byte advance between two reads w + 2 clocks apart
	task automatic delta(input logic [7:0] ca, input byte_t cv,
		input logic [7:0] cnt, input logic idl, input int w, output byte_t d);
		byte_t a;
		byte_t b;
		reg_wr(ca, cv);
		idle = idl;
		reg_rd(cnt, a);
		repeat (w) @(posedge clock_i);
		reg_rd(cnt, b);
		d = b - a;
	endtask

	task automatic t_regs();
		byte_t d;
		reg_rd(8'ha4, d);
		check(16'(d), 16'h0000);
		reg_wr(8'ha4, 8'h0c);
		reg_wr(8'he0, 8'h55);
		reg_rd(8'ha4, d);
		check(16'(d), 16'h0000);
		reg_rd(8'he0, d);
		check(16'(d), 16'h0000);
	endtask

	task automatic t_pwm8();
		byte_t d;
		int h;
		reg_wr(8'hc8, 8'h80);
		reg_wr(8'hd0, 8'h40);
		reg_wr(8'hc0, 8'h02);
		reg_rd(8'hc0, d);
		check(16'(d), 16'h0082);
		reg_wr(8'ha4, 8'h40);
		wait_sig(8'h00, 1'b1, 300);
		wait_sig(8'h00, 1'b0, 300);
		highs(0, 256, h);
		check(16'(h), 16'h00bf);
		reg_wr(8'hc8, 8'h80);
		reg_rd(8'hc0, d);
		check(16'(d), 16'h0002);
		wait_sig(8'h00, 1'b0, 300);
		highs(0, 300, h);
		check(16'(h), 16'h0000);
	endtask

	task automatic t_pwm16();
		int h;
		reg_wr(8'hca, 8'h00);
		reg_wr(8'hd2, 8'h00);
		reg_wr(8'hc2, 8'h03);
		wait_sig(8'h02, 1'b1, 8);
		highs(2, 100, h);
		check(16'(h), 16'h0064);
		reg_wr(8'hca, 8'hff);
		reg_wr(8'hd2, 8'hff);
		wait_sig(8'h02, 1'b0, 8);
		highs(2, 100, h);
		check(16'(h), 16'h0000);
	endtask

	task automatic t_toggle();
		byte_t lo;
		byte_t hi;
		logic [15:0] t;
		logic p;
		int h;
		reg_wr(8'ha4, 8'h00);
		reg_rd(8'ha6, lo);
		reg_rd(8'ha7, hi);
		t = {hi, lo} + 16'h0020;
		reg_wr(8'hc9, t[7:0]);
		reg_wr(8'hd1, t[15:8]);
		reg_wr(8'hc1, 8'h01);
		p = pin[1];
		reg_wr(8'ha4, 8'h40);
		wait_sig(8'h01, ~p, 64);
		highs(1, 100, h);
		check(16'(h), p ? 16'h0000 : 16'h0064);
	endtask

	task automatic t_pwm10();
		int h;
		for (int n = 3; n < 6; n++) begin
			reg_wr(8'hc8 + 8'(n), 8'h00);
			reg_wr(8'hd0 + 8'(n), 8'hfe);
			reg_wr(8'hc0 + 8'(n), 8'h04);
		end
		reg_wr(8'ha4, 8'hc0);
		wait_sig(8'h03, 1'b1, 1100);
		wait_sig(8'h03, 1'b0, 1100);
		highs(3, 1024, h);
		check(16'(h), 16'h01ff);
		highs(4, 1024, h);
		check(16'(h), 16'h01ff);
		highs(5, 1024, h);
		check(16'(h), 16'h01ff);
	endtask

	task automatic t_irq();
		byte_t d;
		reg_wr(8'hbc, 8'h60);
		wait_sig(8'h07, 1'b1, 1100);
		check(16'(irq[0]), 16'h0000);
		reg_rd(8'ha5, d);
		check(16'(d[1]), 16'h0001);
		reg_wr(8'ha5, 8'h01);
		check(16'(irq[1]), 16'h0000);
		wait_sig(8'h07, 1'b1, 1100);
		reg_rd(8'hbc, d);
		check(16'(d), 16'h0060);
	endtask

	task automatic t_counter();
		byte_t d;
		delta(8'ha4, 8'h00, 8'hbd, 1'b0, 40, d);
		check(16'(d), 16'h002a);
		delta(8'ha4, 8'h00, 8'ha6, 1'b0, 40, d);
		check(16'(d), 16'h0000);
		delta(8'ha4, 8'h41, 8'ha6, 1'b0, 40, d);
		check(16'(d), 16'h0015);
		delta(8'ha4, 8'h42, 8'ha6, 1'b0, 46, d);
		check(16'(d), 16'h000c);
		delta(8'ha4, 8'h43, 8'ha6, 1'b0, 46, d);
		check(16'(d), 16'h0006);
		delta(8'ha4, 8'h50, 8'ha6, 1'b1, 40, d);
		check(16'(d), 16'h0000);
		delta(8'ha4, 8'h40, 8'ha6, 1'b1, 40, d);
		check(16'(d), 16'h002a);
		idle = 1'b0;
	endtask

	initial begin
		rstn_i = 1'b0;
		sfr_wr = 1'b0;
		sfr_rd = 1'b0;
		idle = 1'b0;
		addr = 8'h00;
		wdata = 8'h00;
		err_total = 0;
		check_count = 0;
		repeat (10) @(posedge clock_i);
		#1 rstn_i = 1'b1;
		t_regs();
		t_pwm8();
		t_pwm16();
		t_toggle();
		t_pwm10();
		t_irq();
		t_counter();
		complete_run();
	end
endmodule
`default_nettype wire
